// file: pdc_pkg.sv
// Register map, field layout and state encodings of the packet DMA channel configuration block
// Behaviour
// - A 32-bit read-only register returns the engine revision; writes do nothing.
// - Teardown queue select bits 13-12 choose one of four queue managers.
// - Teardown queue select bits 11-0 name the queue teardown descriptors come from.
// - With free-run and graceful-halt both clear, debug suspend changes nothing.
// - Free-run clear, graceful-halt set: suspend halts after the current transaction.
// - Free-run set: debug suspend is ignored whatever graceful-halt says.
// - Transmit bit 31 enables the channel; hardware clears it when teardown completes.
// - Transmit bit 30 written one requests teardown and stays set afterwards.
// - Transmit bits 13-12 and 11-0 give the teardown completion manager and queue.
// - Receive bit 31 enables the channel; hardware clears it when teardown completes.
// - Receive bit 30 is set by hardware at teardown completion; software clears it.
// - Error mode zero: starvation drops the packet and returns used resources.
// - Error mode one: starvation idles without saving state and retries later.
// - Receive bits 23-16 give bytes skipped in the first buffer of a packet.
// - Receive bits 15-14 give the default descriptor kind, overridable per packet.
// - Four transmit and four receive channels, each with its own register.
// - Receive bits 13-12 and 11-0 give default completion manager and queue.
package pdc_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned ADDR_W = 8;
  // Arbitrary neutral revision value
  localparam logic [31:0] REVISION = 32'h0001_0000;
  localparam logic [7:0] OFF_REV = 8'h00;
  localparam logic [7:0] OFF_TDQ = 8'h04;
  localparam logic [7:0] OFF_DBG = 8'h08;
  localparam logic [3:0] PAGE_TX = 4'h1;
  localparam logic [3:0] PAGE_RX = 4'h2;
  localparam logic [7:0] OFF_TX0 = 8'h10;
  localparam logic [7:0] OFF_RX0 = 8'h20;
  localparam logic [31:0] TDQ_MASK = 32'h0000_3FFF;
  localparam logic [31:0] DBG_MASK = 32'h0000_0003;
  localparam logic [31:0] TX_MASK = 32'hC000_3FFF;
  localparam logic [31:0] RX_MASK = 32'hC1FF_FFFF;
  localparam int unsigned ENA_BIT = 31;
  localparam int unsigned TD_BIT = 30;
  localparam int unsigned ERR_BIT = 24;
  localparam int unsigned SKIP_LSB = 16;
  localparam int unsigned KIND_LSB = 14;
  localparam int unsigned MGR_LSB = 12;
  localparam int unsigned FREE_BIT = 0;
  localparam int unsigned SOFT_BIT = 1;
  typedef enum logic [1:0] {
    HS_RUN = 2'b00,
    HS_DRAIN = 2'b01,
    HS_HALT = 2'b11
  } pdc_halt_t;
endpackage

// file: pdc_top.sv
// Packet DMA channel configuration registers, debug suspend control and channel teardown bookkeeping
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/100ps
module pdc_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Debug suspend
  input wire logic dbg_suspend,
  input wire logic xfer_busy,
  output logic engine_halt,
  // Teardown descriptor pool
  output logic [1:0] teardown_pool_manager,
  output logic [11:0] teardown_pool_queue,
  // Transmit channels
  input wire logic [3:0] tx_td_done,
  output logic [3:0] tx_chan_enable,
  output logic [3:0] tx_td_req,
  output logic [3:0][1:0] tx_completion_manager,
  output logic [3:0][11:0] tx_completion_queue,
  // Receive channels
  input wire logic [3:0] rx_td_done,
  output logic [3:0] rx_chan_enable,
  output logic [3:0] rx_td_req,
  output logic [3:0] rx_td_flag,
  // Receive starvation
  input wire logic rx_starve,
  input wire logic [1:0] rx_starve_ch,
  output logic rx_pkt_drop,
  output logic rx_fifo_retry,
  // Receive packet start with per-packet overrides from the FIFO block
  input wire logic rx_pkt_start,
  input wire logic [1:0] rx_pkt_ch,
  input wire logic rx_ovr_kind_vld,
  input wire logic [1:0] rx_ovr_kind,
  input wire logic rx_ovr_queue_vld,
  input wire logic [1:0] rx_ovr_manager,
  input wire logic [11:0] rx_ovr_queue,
  output logic rx_eff_vld,
  output logic [1:0] rx_eff_kind,
  output logic [1:0] rx_eff_manager,
  output logic [11:0] rx_eff_queue,
  output logic [7:0] rx_eff_skip
);

  typedef struct packed {
    logic [31:0] tdq;
    logic [1:0] dbg;
    logic [3:0][31:0] tx;
    logic [3:0][31:0] rx;
    logic [31:0] rdata;
    pdc_pkg::pdc_halt_t hs;
    logic halt;
    logic [3:0] tx_req;
    logic [3:0] rx_req;
    logic drop;
    logic retry;
    logic eff_vld;
    logic [1:0] eff_kind;
    logic [1:0] eff_mgr;
    logic [11:0] eff_qnum;
    logic [7:0] eff_skip;
  } pdc_state_t;

  pdc_state_t s_q;
  pdc_state_t s_d;
  logic [1:0] rst_sync_q;
  logic rst_ok;

  // Channel index within a register page
  function automatic logic [1:0] pdc_chan(input logic [7:0] a);
    pdc_chan = a[3:2];
  endfunction

  // Register page of an address; channel registers sit in their own 16-byte page
  function automatic logic [3:0] pdc_page(input logic [7:0] a);
    pdc_page = a[7:4];
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_q[1];

  always_comb begin
    s_d = s_q;
    s_d.rdata = 32'h0000_0000;
    s_d.drop = 1'b0;
    s_d.retry = 1'b0;
    s_d.eff_vld = 1'b0;

    // Software writes; masks drop reserved bits
    if (wr_en) begin
      if (addr == pdc_pkg::OFF_TDQ) begin
        s_d.tdq = wr_data & pdc_pkg::TDQ_MASK;
      end else if (addr == pdc_pkg::OFF_DBG) begin
        s_d.dbg = wr_data[1:0];
      end else if (pdc_page(addr) == pdc_pkg::PAGE_TX) begin
        s_d.tx[pdc_chan(addr)] = wr_data & pdc_pkg::TX_MASK;
      end else if (pdc_page(addr) == pdc_pkg::PAGE_RX) begin
        s_d.rx[pdc_chan(addr)] = wr_data & pdc_pkg::RX_MASK;
      end
    end

    // Teardown completion follows the write so hardware wins a same-cycle collision
    for (int i = 0; i < pdc_pkg::NUM_CH; i++) begin
      if (tx_td_done[i]) begin
        s_d.tx[i][pdc_pkg::ENA_BIT] = 1'b0;
      end
      if (rx_td_done[i]) begin
        s_d.rx[i][pdc_pkg::ENA_BIT] = 1'b0;
        s_d.rx[i][pdc_pkg::TD_BIT] = 1'b1;
      end
      // Teardown bit is never cleared by hardware, so a done channel shows enable low, teardown high
      s_d.tx_req[i] = s_d.tx[i][pdc_pkg::ENA_BIT] & s_d.tx[i][pdc_pkg::TD_BIT];
      s_d.rx_req[i] = s_d.rx[i][pdc_pkg::ENA_BIT] & s_d.rx[i][pdc_pkg::TD_BIT];
    end

    // Starvation handling by the channel's error mode
    if (rx_starve) begin
      if (s_q.rx[rx_starve_ch][pdc_pkg::ERR_BIT]) begin
        s_d.retry = 1'b1;
      end else begin
        s_d.drop = 1'b1;
      end
    end

    // Per-packet settings: FIFO block overrides take priority over channel defaults
    if (rx_pkt_start) begin
      s_d.eff_vld = 1'b1;
      s_d.eff_skip = s_q.rx[rx_pkt_ch][pdc_pkg::SKIP_LSB +: 8];
      if (rx_ovr_kind_vld) begin
        s_d.eff_kind = rx_ovr_kind;
      end else begin
        s_d.eff_kind = s_q.rx[rx_pkt_ch][pdc_pkg::KIND_LSB +: 2];
      end
      if (rx_ovr_queue_vld) begin
        s_d.eff_mgr = rx_ovr_manager;
        s_d.eff_qnum = rx_ovr_queue;
      end else begin
        s_d.eff_mgr = s_q.rx[rx_pkt_ch][pdc_pkg::MGR_LSB +: 2];
        s_d.eff_qnum = s_q.rx[rx_pkt_ch][11:0];
      end
    end

    // Debug suspend; a graceful halt waits for the transaction in flight
    case (s_q.hs)
      pdc_pkg::HS_RUN: begin
        if (dbg_suspend && s_q.dbg[pdc_pkg::SOFT_BIT] && !s_q.dbg[pdc_pkg::FREE_BIT]) begin
          s_d.hs = xfer_busy ? pdc_pkg::HS_DRAIN : pdc_pkg::HS_HALT;
        end
      end
      pdc_pkg::HS_DRAIN: begin
        if (!dbg_suspend || s_q.dbg[pdc_pkg::FREE_BIT] || !s_q.dbg[pdc_pkg::SOFT_BIT]) begin
          s_d.hs = pdc_pkg::HS_RUN;
        end else if (!xfer_busy) begin
          s_d.hs = pdc_pkg::HS_HALT;
        end
      end
      pdc_pkg::HS_HALT: begin
        if (!dbg_suspend || s_q.dbg[pdc_pkg::FREE_BIT] || !s_q.dbg[pdc_pkg::SOFT_BIT]) begin
          s_d.hs = pdc_pkg::HS_RUN;
        end
      end
      default: begin
        s_d.hs = pdc_pkg::HS_RUN;
      end
    endcase
    s_d.halt = (s_d.hs == pdc_pkg::HS_HALT);

    // Read data stands only in the cycle after the strobe; unmapped reads give zero
    if (rd_en) begin
      if (addr == pdc_pkg::OFF_REV) begin
        s_d.rdata = pdc_pkg::REVISION;
      end else if (addr == pdc_pkg::OFF_TDQ) begin
        s_d.rdata = s_q.tdq;
      end else if (addr == pdc_pkg::OFF_DBG) begin
        s_d.rdata = {30'h000_0000, s_q.dbg};
      end else if (pdc_page(addr) == pdc_pkg::PAGE_TX) begin
        s_d.rdata = s_q.tx[pdc_chan(addr)];
      end else if (pdc_page(addr) == pdc_pkg::PAGE_RX) begin
        s_d.rdata = s_q.rx[pdc_chan(addr)];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (!rst_ok) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rdata;
  assign engine_halt = s_q.halt;
  assign teardown_pool_manager = s_q.tdq[pdc_pkg::MGR_LSB +: 2];
  assign teardown_pool_queue = s_q.tdq[11:0];
  assign tx_td_req = s_q.tx_req;
  assign rx_td_req = s_q.rx_req;
  assign rx_pkt_drop = s_q.drop;
  assign rx_fifo_retry = s_q.retry;
  assign rx_eff_vld = s_q.eff_vld;
  assign rx_eff_kind = s_q.eff_kind;
  assign rx_eff_manager = s_q.eff_mgr;
  assign rx_eff_queue = s_q.eff_qnum;
  assign rx_eff_skip = s_q.eff_skip;

  for (genvar g = 0; g < pdc_pkg::NUM_CH; g++) begin : g_ch
    assign tx_chan_enable[g] = s_q.tx[g][pdc_pkg::ENA_BIT];
    assign tx_completion_manager[g] = s_q.tx[g][pdc_pkg::MGR_LSB +: 2];
    assign tx_completion_queue[g] = s_q.tx[g][11:0];
    assign rx_chan_enable[g] = s_q.rx[g][pdc_pkg::ENA_BIT];
    assign rx_td_flag[g] = s_q.rx[g][pdc_pkg::TD_BIT];
  end

  // Helpers read only by the checks below
  logic [1:0] def_kind_sel;
  logic [13:0] wr_low;
  logic starve_mode;
  logic [13:0] def_queue_sel;
  logic [7:0] skip_sel;
  assign def_kind_sel = s_q.rx[rx_pkt_ch][pdc_pkg::KIND_LSB +: 2];
  assign wr_low = wr_data[13:0];
  assign starve_mode = s_q.rx[rx_starve_ch][pdc_pkg::ERR_BIT];
  assign def_queue_sel = s_q.rx[rx_pkt_ch][13:0];
  assign skip_sel = s_q.rx[rx_pkt_ch][pdc_pkg::SKIP_LSB +: 8];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_ok);

  sequence s_soft_idle_suspend;
    dbg_suspend && (s_q.dbg == 2'b10) && !xfer_busy && (s_q.hs == pdc_pkg::HS_RUN);
  endsequence

  sequence s_busy_not_halted;
    xfer_busy && (s_q.hs != pdc_pkg::HS_HALT);
  endsequence

  sequence s_soft_busy_run;
    dbg_suspend && (s_q.dbg == 2'b10) && xfer_busy && (s_q.hs == pdc_pkg::HS_RUN);
  endsequence

  sequence s_soft_busy_drain;
    dbg_suspend && (s_q.dbg == 2'b10) && xfer_busy && (s_q.hs == pdc_pkg::HS_DRAIN);
  endsequence

  sequence s_soft_idle_drain;
    dbg_suspend && (s_q.dbg == 2'b10) && !xfer_busy && (s_q.hs == pdc_pkg::HS_DRAIN);
  endsequence

  a_rev_read: assert property (rd_en && addr == pdc_pkg::OFF_REV |=> rd_data == pdc_pkg::REVISION)
    else $error("revision register read wrong");
  a_tdq_fields: assert property (wr_en && addr == pdc_pkg::OFF_TDQ |=>
    {teardown_pool_manager, teardown_pool_queue} == $past(wr_low))
    else $error("teardown queue select not stored");
  a_plain_no_halt: assert property (s_q.dbg == 2'b00 |=> !engine_halt)
    else $error("halt with suspend modes off");
  a_soft_halts: assert property (s_soft_idle_suspend |=> engine_halt)
    else $error("graceful halt missed");
  a_halt_waits: assert property (s_busy_not_halted |=> !engine_halt)
    else $error("halted during a transaction");
  a_free_ignores: assert property (s_q.dbg[pdc_pkg::FREE_BIT] |=> !engine_halt)
    else $error("halt while free running");
  a_tx_en_clear: assert property (|tx_td_done |=> (tx_chan_enable & $past(tx_td_done)) == 4'h0)
    else $error("transmit enable kept after teardown");
  a_tx_td_kept: assert property (s_q.tx[0][pdc_pkg::TD_BIT] && !(wr_en && addr == pdc_pkg::OFF_TX0)
    |=> s_q.tx[0][pdc_pkg::TD_BIT])
    else $error("transmit teardown bit lost");
  a_rx_td_done: assert property (|rx_td_done |=>
    ((rx_td_flag & $past(rx_td_done)) == $past(rx_td_done)) && ((rx_chan_enable & $past(rx_td_done)) == 4'h0))
    else $error("receive teardown completion not recorded");
  a_starve_drop: assert property (rx_starve && !starve_mode |=> rx_pkt_drop && !rx_fifo_retry)
    else $error("starvation did not drop");
  a_starve_retry: assert property (rx_starve && starve_mode |=> rx_fifo_retry && !rx_pkt_drop)
    else $error("starvation did not retry");
  a_default_kind: assert property (rx_pkt_start && !rx_ovr_kind_vld |=>
    rx_eff_vld && rx_eff_kind == $past(def_kind_sel))
    else $error("default descriptor kind not used");
  a_dbg_reserved: assert property (rd_en && addr == pdc_pkg::OFF_DBG |=> rd_data[31:2] == 30'h000_0000)
    else $error("reserved bits read nonzero");

  // Field storage and stability between writes
  a_tdq_stable: assert property (!(wr_en && addr == pdc_pkg::OFF_TDQ) |=>
    $stable(teardown_pool_queue) && $stable(teardown_pool_manager))
    else $error("teardown queue select changed without a write");

  a_tx_fields: assert property (wr_en && addr == pdc_pkg::OFF_TX0 |=>
    {tx_completion_manager[0], tx_completion_queue[0]} == $past(wr_low))
    else $error("transmit completion queue not stored");

  a_tx_fields_stable: assert property (!wr_en |=>
    $stable(tx_completion_queue) && $stable(tx_completion_manager))
    else $error("transmit completion queue changed without a write");

  // Teardown bookkeeping
  a_tx_req_drop: assert property (|tx_td_done |=> (tx_td_req & $past(tx_td_done)) == 4'h0)
    else $error("transmit teardown request kept after completion");

  a_rx_req_drop: assert property (|rx_td_done |=> (rx_td_req & $past(rx_td_done)) == 4'h0)
    else $error("receive teardown request kept after completion");

  a_rx_flag_kept: assert property (!wr_en |=>
    (rx_td_flag & $past(rx_td_flag)) == $past(rx_td_flag))
    else $error("receive teardown flag cleared by hardware");

  // Starvation and per-packet settings
  a_starve_quiet: assert property (!rx_starve |=> !rx_pkt_drop && !rx_fifo_retry)
    else $error("starvation answer without an event");

  a_skip_used: assert property (rx_pkt_start |=>
    rx_eff_skip == $past(skip_sel))
    else $error("first buffer skip not taken from channel");

  a_kind_override: assert property (rx_pkt_start && rx_ovr_kind_vld |=>
    rx_eff_kind == $past(rx_ovr_kind))
    else $error("descriptor kind override ignored");

  a_default_queue: assert property (rx_pkt_start && !rx_ovr_queue_vld |=>
    {rx_eff_manager, rx_eff_queue} == $past(def_queue_sel))
    else $error("default completion queue not used");

  a_queue_override: assert property (rx_pkt_start && rx_ovr_queue_vld |=>
    rx_eff_queue == $past(rx_ovr_queue) && rx_eff_manager == $past(rx_ovr_manager))
    else $error("completion queue override ignored");

  a_eff_holds: assert property (!rx_pkt_start |=>
    !rx_eff_vld && $stable(rx_eff_queue) && $stable(rx_eff_skip))
    else $error("packet settings changed without a start");

  // Debug suspend steps
  a_plain_stays_run: assert property (s_q.dbg == 2'b00 && s_q.hs == pdc_pkg::HS_RUN |=> s_q.hs == pdc_pkg::HS_RUN)
    else $error("left run state with suspend modes off");

  a_busy_drains: assert property (s_soft_busy_run |=> s_q.hs == pdc_pkg::HS_DRAIN && !engine_halt)
    else $error("busy suspend did not start draining");

  a_drain_holds: assert property (s_soft_busy_drain |=> s_q.hs == pdc_pkg::HS_DRAIN)
    else $error("drain left while transaction in flight");

  a_drain_ends: assert property (s_soft_idle_drain |=> engine_halt)
    else $error("no halt after transaction finished");

  a_drain_exits: assert property (s_q.hs == pdc_pkg::HS_DRAIN && !dbg_suspend |=> s_q.hs == pdc_pkg::HS_RUN)
    else $error("drain kept after suspend dropped");

  a_halt_holds: assert property (engine_halt && dbg_suspend && s_q.dbg == 2'b10 |=> engine_halt)
    else $error("halt released while suspend held");

  a_suspend_drops: assert property (engine_halt && !dbg_suspend |=> !engine_halt)
    else $error("halt kept after suspend dropped");

  a_free_state: assert property (s_q.dbg[pdc_pkg::FREE_BIT] |=> s_q.hs == pdc_pkg::HS_RUN)
    else $error("suspend state entered while free running");

  // Read port
  a_tdq_reserved: assert property (rd_en && addr == pdc_pkg::OFF_TDQ |=> rd_data[31:14] == 18'h0000)
    else $error("teardown select reserved bits read nonzero");

  a_tx_reserved: assert property (rd_en && pdc_page(addr) == pdc_pkg::PAGE_TX |=>
    (rd_data & ~pdc_pkg::TX_MASK) == 32'h0000_0000)
    else $error("transmit reserved bits read nonzero");

  a_rx_reserved: assert property (rd_en && pdc_page(addr) == pdc_pkg::PAGE_RX |=>
    (rd_data & ~pdc_pkg::RX_MASK) == 32'h0000_0000)
    else $error("receive reserved bits read nonzero");

  a_rd_idle: assert property (!rd_en |=> rd_data == 32'h0000_0000)
    else $error("read data without a read strobe");

endmodule

// file: pdc_qmgr_model.sv
// Queue manager stand-in that answers channel teardown requests with completion pulses
`timescale 1ns/100ps
module pdc_qmgr_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Answer delay in cycles, zero is prompt
  input wire logic [3:0] delay,
  // Teardown handshake
  input wire logic [3:0] tx_td_req,
  input wire logic [3:0] rx_td_req,
  output logic [3:0] tx_td_done,
  output logic [3:0] rx_td_done
);
  logic [7:0] req;
  logic [7:0] done_q;
  logic [3:0] cnt_q [8];
  assign req = {rx_td_req, tx_td_req};
  assign tx_td_done = done_q[3:0];
  assign rx_td_done = done_q[7:4];
  // One completion pulse per request; the request drops before a second could be counted
  always @(posedge clk_sys or negedge rst_n) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_n) begin
        done_q[i] <= 1'b0;
        cnt_q[i] <= 4'h0;
      end else if (req[i] && !done_q[i]) begin
        done_q[i] <= (cnt_q[i] == delay);
        cnt_q[i] <= (cnt_q[i] == delay) ? 4'h0 : cnt_q[i] + 4'h1;
      end else begin
        done_q[i] <= 1'b0;
        cnt_q[i] <= 4'h0;
      end
    end
  end
endmodule

// file: packet_dma_channel_config_tb.sv
// Self-checking bench for the packet DMA channel configuration block
`timescale 1ns/100ps
module packet_dma_channel_config_tb;
  logic clk_sys, rst_n, wr_en, rd_en, dbg_suspend, xfer_busy, engine_halt, rx_starve;
  logic [7:0] en_all, req_all;
  logic [7:0] addr;
  logic [31:0] wr_data, rd_data, r;
  logic [1:0] teardown_pool_manager, ch;
  logic [11:0] teardown_pool_queue;
  logic [3:0] tx_td_done, tx_chan_enable, tx_td_req, rx_td_done, rx_chan_enable, rx_td_req, rx_td_flag, qm_delay;
  logic [3:0][1:0] tx_completion_manager;
  logic [3:0][11:0] tx_completion_queue;
  logic [1:0] rx_starve_ch, rx_pkt_ch, rx_ovr_kind, rx_ovr_manager, rx_eff_kind, rx_eff_manager;
  logic rx_pkt_drop, rx_fifo_retry, rx_pkt_start, rx_ovr_kind_vld, rx_ovr_queue_vld, rx_eff_vld;
  logic [11:0] rx_ovr_queue, rx_eff_queue;
  logic [7:0] rx_eff_skip;
  logic [31:0] sh [8];
  int miscompares = 0;
  int n_tests = 0;

  pdc_top u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .dbg_suspend(dbg_suspend), .xfer_busy(xfer_busy), .engine_halt(engine_halt),
    .teardown_pool_manager(teardown_pool_manager), .teardown_pool_queue(teardown_pool_queue),
    .tx_td_done(tx_td_done), .tx_chan_enable(tx_chan_enable), .tx_td_req(tx_td_req),
    .tx_completion_manager(tx_completion_manager), .tx_completion_queue(tx_completion_queue),
    .rx_td_done(rx_td_done), .rx_chan_enable(rx_chan_enable), .rx_td_req(rx_td_req), .rx_td_flag(rx_td_flag),
    .rx_starve(rx_starve), .rx_starve_ch(rx_starve_ch), .rx_pkt_drop(rx_pkt_drop), .rx_fifo_retry(rx_fifo_retry),
    .rx_pkt_start(rx_pkt_start), .rx_pkt_ch(rx_pkt_ch), .rx_ovr_kind_vld(rx_ovr_kind_vld), .rx_ovr_kind(rx_ovr_kind),
    .rx_ovr_queue_vld(rx_ovr_queue_vld), .rx_ovr_manager(rx_ovr_manager), .rx_ovr_queue(rx_ovr_queue),
    .rx_eff_vld(rx_eff_vld), .rx_eff_kind(rx_eff_kind), .rx_eff_manager(rx_eff_manager),
    .rx_eff_queue(rx_eff_queue), .rx_eff_skip(rx_eff_skip));

  pdc_qmgr_model u_qmgr (.clk_sys(clk_sys), .rst_n(rst_n), .delay(qm_delay), .tx_td_req(tx_td_req),
    .rx_td_req(rx_td_req), .tx_td_done(tx_td_done), .rx_td_done(rx_td_done));
  assign en_all = {rx_chan_enable, tx_chan_enable};
  assign req_all = {rx_td_req, tx_td_req};

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1 chk(rd_data, exp);
  endtask

  // Index 0-3 are transmit channels, 4-7 receive channels
  function logic [7:0] cfg_addr(input int j);
    cfg_addr = (j < 4) ? pdc_pkg::OFF_TX0 + 8'(4 * j) : pdc_pkg::OFF_RX0 + 8'(4 * (j - 4));
  endfunction

  function logic [31:0] cfg_mask(input int j);
    cfg_mask = (j < 4) ? pdc_pkg::TX_MASK : pdc_pkg::RX_MASK;
  endfunction

  // Resolved kind, manager, queue and skip for a packet start with random override bits r
  function logic [23:0] exp_eff(input logic [31:0] g, input logic [31:0] v);
    exp_eff = {v[0] ? v[2:1] : g[15:14], v[3] ? {v[5:4], v[17:6]} : g[13:0], g[23:16]};
  endfunction

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    give_verdict();
  end

  initial begin
    {rst_n, wr_en, rd_en, dbg_suspend, xfer_busy, rx_starve, rx_pkt_start} = '0;
    {addr, wr_data, rx_starve_ch, rx_pkt_ch, rx_ovr_kind_vld, rx_ovr_kind} = '0;
    {rx_ovr_queue_vld, rx_ovr_manager, rx_ovr_queue, qm_delay} = '0;
    void'($urandom(85));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(pdc_pkg::OFF_REV, pdc_pkg::REVISION);
    wr(pdc_pkg::OFF_REV, $urandom);
    rd(pdc_pkg::OFF_REV, pdc_pkg::REVISION);
    for (int j = 0; j < 8; j++) rd(cfg_addr(j), 32'h0000_0000);
    wr(8'h0C, $urandom);
    rd(8'h0C, 32'h0000_0000);
    repeat (6) begin
      r = $urandom;
      wr(pdc_pkg::OFF_TDQ, r);
      rd(pdc_pkg::OFF_TDQ, r & pdc_pkg::TDQ_MASK);
      chk({18'h0, teardown_pool_manager, teardown_pool_queue}, r & pdc_pkg::TDQ_MASK);
      for (int j = 0; j < 8; j++) begin
        sh[j] = $urandom & 32'h3FFF_FFFF;
        wr(cfg_addr(j), sh[j]);
      end
      for (int j = 0; j < 8; j++) rd(cfg_addr(j), sh[j] & cfg_mask(j));
      for (int i = 0; i < 4; i++) chk({18'h0, tx_completion_manager[i], tx_completion_queue[i]}, sh[i] & 32'h3FFF);
    end
    sh[4][24] = 1'b1;
    sh[5][24] = 1'b0;
    wr(cfg_addr(4), sh[4]);
    wr(cfg_addr(5), sh[5]);
    repeat (12) begin
      ch = 2'($urandom);
      @(posedge clk_sys);
      rx_starve <= 1'b1;
      rx_starve_ch <= ch;
      @(posedge clk_sys);
      rx_starve <= 1'b0;
      #1 chk(32'({rx_pkt_drop, rx_fifo_retry}), 32'({~sh[4 + ch][24], sh[4 + ch][24]}));
    end
    repeat (12) begin
      ch = 2'($urandom);
      r = $urandom;
      @(posedge clk_sys);
      {rx_pkt_start, rx_pkt_ch, rx_ovr_kind_vld, rx_ovr_kind} <= {1'b1, ch, r[0], r[2:1]};
      {rx_ovr_queue_vld, rx_ovr_manager, rx_ovr_queue} <= {r[3], r[5:4], r[17:6]};
      @(posedge clk_sys);
      rx_pkt_start <= 1'b0;
      #1 chk(32'(rx_eff_vld), 32'h1);
      chk({8'h0, rx_eff_kind, rx_eff_manager, rx_eff_queue, rx_eff_skip}, {8'h0, exp_eff(sh[4 + ch], r)});
    end
    for (int m = 0; m < 4; m++) begin
      wr(pdc_pkg::OFF_DBG, 32'(m));
      rd(pdc_pkg::OFF_DBG, 32'(m));
      @(posedge clk_sys);
      dbg_suspend <= 1'b1;
      xfer_busy <= 1'b1;
      repeat (3) @(posedge clk_sys);
      #1 chk(32'(engine_halt), 32'h0);
      @(posedge clk_sys);
      xfer_busy <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk(32'(engine_halt), 32'(m == 2));
      @(posedge clk_sys);
      dbg_suspend <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1 chk(32'(engine_halt), 32'h0);
    end
    // Suspend with no transaction in flight halts without a drain step
    wr(pdc_pkg::OFF_DBG, 32'h0000_0002);
    @(posedge clk_sys);
    dbg_suspend <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk(32'(engine_halt), 32'h1);
    @(posedge clk_sys);
    dbg_suspend <= 1'b0;
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_sys);
      // Prompt answers on the last two receive channels let the done pulse meet a software write
      qm_delay <= (j >= 6) ? 4'h0 : 4'($urandom % 8);
      r = sh[j] & cfg_mask(j) & 32'h3FFF_FFFF;
      // Receive side enables first and requests teardown with a second write to the same channel register
      if (j >= 4) wr(cfg_addr(j), 32'h8000_0000 | r);
      wr(cfg_addr(j), 32'hC000_0000 | r);
      #1 chk(32'(en_all[j]), 32'h1);
      // Lands with the done pulse and clears bit 30; hardware must win
      if (j >= 6) wr(cfg_addr(j), 32'h8000_0000 | r);
      for (int n = 0; n < 40 && en_all[j] !== 1'b0; n++) begin
        @(posedge clk_sys);
        #1;
      end
      chk(32'(req_all[j]), 32'h0);
      if (j >= 4) chk(32'(rx_td_flag[j - 4]), 32'h1);
      rd(cfg_addr(j), 32'h4000_0000 | r);
    end
    give_verdict();
  end
endmodule
